// File: pkg/dram_cmd_pkg.sv
// What this block does
// - With dual-load DQ termination, any READ turns DQ termination off, chip select ignored.
// - Termination-off window starts CL-1 clocks after READ, lasts BL/2 plus two clocks.
// - READs addressed to either rank are snooped and drop our own DQ termination.
// - Termination on clock-enable stays enabled at all times; the other non-DQ pins lose it in self refresh.
// - Auto row close chosen per READ/WRITE by the auto-close bit; never persists.
// - Auto close starts at earliest legal explicit-close point, honouring row-active time.
// - Refreshes spaced at most 3.9us average; device makes row addresses, ignores address pins.
// - Refresh with clock-enable low enters self refresh; only clock-enable is then heard.
// - Self refresh turns DLL and termination off; exit re-enables termination, resets DLL.
// - READ with auto close closes row BL/2 clocks after the READ once row-active time is met.
// - First word CAS latency after READ, later words on successive strobe edges, edge aligned.
// - One preamble cycle before first strobe rise: half high, half low.
// - Postamble: half low with the last word, then half high.
// - Strobe toggles only from preamble through postamble; DQ and strobe tri-state after the burst.
// - Read bursts always run full length; later commands never cut them short.
package dram_cmd_pkg;
   localparam logic [7:0]  CONFIG_OFS     = 8'h00;
   localparam logic [7:0]  STATUS_OFS     = 8'h04;
   localparam logic [7:0]  REFROW_OFS     = 8'h08;
   localparam logic [7:0]  BANKS_OFS      = 8'h0C;

   localparam int          CFG_CL_LSB     = 0;
   localparam int          CFG_BL8_BIT    = 4;
   localparam int          CFG_DUAL_BIT   = 5;
   localparam logic [3:0]  CL_RESET       = 4'h6;
   localparam logic [3:0]  CL_MIN         = 4'h3;
   localparam logic        BL8_RESET      = 1'b0;
   localparam logic        DUAL_RESET     = 1'b0;

   localparam int          ST_SREF_BIT    = 0;
   localparam int          ST_DLL_BIT     = 1;
   localparam int          ST_DQTERM_BIT  = 2;
   localparam int          ST_RDRDY_BIT   = 3;

   localparam int          NUM_BANKS      = 8;
   localparam int          ROW_W          = 12;
   localparam int          COL_W          = 9;
   localparam int          BANK_W         = 3;
   localparam int          AUTO_CLOSE_BIT = 8;

   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          SREF_INT_NS    = 3900;
   localparam int          SREF_INT_CYC   = SREF_INT_NS / CLK_PERIOD_NS;
   localparam int          TERM_EXTRA_CK  = 2;
   localparam int          READ_WAIT_CK   = 5000;
   localparam int          RAS_MIN_CK     = 8;
   localparam int          RP_CK          = 4;
endpackage

// File: design/sync2.sv
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,    // System clock
   input  wire logic         resetn, // Synchronous reset, active low
   input  wire logic [W-1:0] d,      // Asynchronous inputs
   output logic      [W-1:0] q       // Synchronised outputs
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

// File: design/bank_tracker.sv
`timescale 1ns/100ps
`default_nettype none
module bank_tracker
   import dram_cmd_pkg::*;
#(
   parameter int RAS_MIN = RAS_MIN_CK,
   parameter int RP      = RP_CK
) (
   input  wire logic       clk,         // System clock
   input  wire logic       resetn,      // Synchronous reset, active low
   input  wire logic       tick,        // Link clock rising edge
   input  wire logic       activate,    // ACTIVE to this bank
   input  wire logic       precharge,   // Explicit PRECHARGE to this bank
   input  wire logic       auto_close,  // READ/WRITE with auto close to this bank
   input  wire logic [2:0] close_delay, // Link clocks from command to earliest close
   output logic            row_open,    // Row is active
   output logic            precharging  // Precharge period running
);
   logic [7:0] ras_cnt_q;
   logic [7:0] rp_cnt_q;
   logic [2:0] ap_cnt_q;
   logic       ap_pend_q;
   logic       ras_met;
   logic       ap_due;

   if (RAS_MIN < 1 || RAS_MIN > 255 || RP < 1 || RP > 255) begin : g_bad_timing
      $error("bank_tracker: bad timing");
   end

   assign ras_met = ras_cnt_q >= 8'(RAS_MIN);
   assign ap_due  = ap_pend_q && ap_cnt_q <= 3'h1;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         row_open    <= 1'b0;
         precharging <= 1'b0;
         ras_cnt_q   <= 8'h00;
         rp_cnt_q    <= 8'h00;
         ap_cnt_q    <= 3'h0;
         ap_pend_q   <= 1'b0;
      end else if (tick) begin
         if (precharging) begin
            if (rp_cnt_q <= 8'h01) begin
               precharging <= 1'b0;
            end
            rp_cnt_q <= rp_cnt_q - 8'h01;
         end else if (!row_open) begin
            if (activate) begin
               row_open  <= 1'b1;
               ras_cnt_q <= 8'h01;
               ap_pend_q <= 1'b0;
            end
         end else begin
            if (!ras_met) begin
               ras_cnt_q <= ras_cnt_q + 8'h01;
            end
            if (precharge || (ap_due && ras_met)) begin
               row_open    <= 1'b0;
               precharging <= 1'b1;
               ap_pend_q   <= 1'b0;
               rp_cnt_q    <= 8'(RP);
            end else if (auto_close) begin
               ap_pend_q <= 1'b1;
               ap_cnt_q  <= close_delay;
            end else if (ap_pend_q && !ap_due) begin
               ap_cnt_q <= ap_cnt_q - 3'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: design/dram_read_ctrl.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module dram_read_ctrl
   import dram_cmd_pkg::*;
#(
   parameter int DQ_W      = 32,
   parameter int MAX_CL    = 15,
   parameter int READ_WAIT = READ_WAIT_CK,
   parameter int SREF_INT  = SREF_INT_CYC,
   parameter int RAS_MIN   = RAS_MIN_CK,
   parameter int RP        = RP_CK
) (
   input  wire logic              clk,           // System clock, 100 MHz
   input  wire logic              resetn,        // Synchronous reset, active low
   input  wire logic              psel,          // APB select
   input  wire logic              penable,       // APB enable
   input  wire logic              pwrite,        // APB write
   input  wire logic [7:0]        paddr,         // APB byte address
   input  wire logic [31:0]       pwdata,        // APB write data
   output logic      [31:0]       prdata,        // APB read data
   output logic                   pready,        // APB ready
   output logic                   pslverr,       // APB error on unmapped address
   input  wire logic              ck,            // Link clock from controller
   input  wire logic              cke,           // Clock enable
   input  wire logic              cs_n,          // Chip select, active low
   input  wire logic              ras_n,         // Row strobe, active low
   input  wire logic              cas_n,         // Column strobe, active low
   input  wire logic              we_n,          // Write enable, active low
   input  wire logic [BANK_W-1:0] ba,            // Bank address
   input  wire logic [ROW_W-1:0]  addr,          // Address, bit 8 is the auto-close select
   output logic      [DQ_W-1:0]   dq_out,        // Read data
   output logic                   dq_oe_n,       // DQ drive enable, low drives
   output logic                   read_data_strobe,    // Read strobe level
   output logic                   read_data_strobe_oe_n, // Strobe drive enable, low drives
   output logic                   dq_term_en,    // DQ on-die termination on
   output logic                   other_term_en, // Termination on other pins on
   output logic                   cke_term_en,   // Termination on clock-enable on
   output logic                   dll_en,        // DLL enabled
   output logic                   dll_reset,     // DLL reset pulse, one clk
   output logic                   self_refresh,  // In self refresh
   output logic                   read_ready     // Read wait after self refresh exit done
);
   localparam int TERM_W = MAX_CL + 8;
   localparam int WAIT_W = $clog2(READ_WAIT + 1);
   localparam int SREF_W = $clog2(SREF_INT + 1);
   localparam int SYN_W  = 6 + BANK_W + ROW_W;

   if (MAX_CL < 3 || MAX_CL > 15 || DQ_W < 16 || READ_WAIT < 1 || SREF_INT < 1) begin : g_bad_param
      $error("dram_read_ctrl: parameter out of range");
   end

   function automatic logic [TERM_W-1:0] win_mask(input logic [3:0] cl, input logic [2:0] bl2);
      logic [TERM_W-1:0] m;
      int lo, hi;
      m  = '0;
      lo = int'(cl) - 1;
      hi = lo + int'(bl2) + TERM_EXTRA_CK - 1;
      for (int i = 0; i < TERM_W; i++) begin
         m[i] = (i >= lo) && (i <= hi);
      end
      return m;
   endfunction

   function automatic logic [3:0] clamp_cl(input logic [3:0] v);
      return (v < CL_MIN) ? CL_MIN : ((v > 4'(MAX_CL)) ? 4'(MAX_CL) : v);
   endfunction

   // Data pattern stands in for the array; it names bank, column and beat.
   function automatic logic [DQ_W-1:0] data_word(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] c,
                                                 input logic [3:0] beat);
      return DQ_W'({b, c, beat});
   endfunction

   // Pins cross into clk through two flops; ck is sampled like any other pin.
   logic [SYN_W-1:0]  syn;
   logic              ck_s, cke_s, cs_s, ras_s, cas_s, we_s;
   logic [BANK_W-1:0] ba_s;
   logic [ROW_W-1:0]  addr_s;
   logic              ck_prev_q;
   logic              cke_prev_q;
   logic              rise, fall, edge_t;

   sync2 #(.W(SYN_W)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr}),
      .q      (syn)
   );
   assign {ck_s, cke_s, cs_s, ras_s, cas_s, we_s, ba_s, addr_s} = syn;
   assign rise   = ck_s && !ck_prev_q;
   assign fall   = !ck_s && ck_prev_q;
   assign edge_t = rise || fall;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ck_prev_q  <= 1'b0;
         cke_prev_q <= 1'b1;
      end else begin
         ck_prev_q <= ck_s;
         if (rise) begin
            cke_prev_q <= cke_s;
         end
      end
   end

   // Configuration and APB
   logic [3:0] cl_q;
   logic       bl8_q;
   logic       dual_q;
   logic [2:0] bl2;
   logic [3:0] bl_halves;
   logic [ROW_W-1:0] ref_row_q;
   logic [NUM_BANKS-1:0] bank_open, bank_pre;

   assign bl2       = bl8_q ? 3'h4 : 3'h2;
   assign bl_halves = bl8_q ? 4'h8 : 4'h4;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         cl_q    <= CL_RESET;
         bl8_q   <= BL8_RESET;
         dual_q  <= DUAL_RESET;
      end else begin
         pready <= psel && !penable;
         if (psel && !penable) begin
            pslverr <= !(paddr == CONFIG_OFS || paddr == STATUS_OFS || paddr == REFROW_OFS || paddr == BANKS_OFS);
            unique case (paddr)
               CONFIG_OFS: prdata <= 32'({dual_q, bl8_q, cl_q});
               STATUS_OFS: prdata <= 32'({read_ready, dq_term_en, dll_en, self_refresh});
               REFROW_OFS: prdata <= 32'(ref_row_q);
               BANKS_OFS:  prdata <= 32'({bank_pre, bank_open});
               default:    prdata <= 32'h0000_0000;
            endcase
         end
         if (psel && penable && pready && pwrite && paddr == CONFIG_OFS) begin
            cl_q   <= clamp_cl(pwdata[CFG_CL_LSB +: 4]);
            bl8_q  <= pwdata[CFG_BL8_BIT];
            dual_q <= pwdata[CFG_DUAL_BIT];
         end
      end
   end

   // Command decode at link rising edges; nothing is heard in self refresh.
   logic live;
   logic cmd_read, cmd_write, cmd_act, cmd_pre, cmd_ref, snoop_read, ap_sel;
   assign live       = rise && !self_refresh && cke_s;
   assign snoop_read = live && ras_s && !cas_s && we_s;
   assign cmd_read   = snoop_read && !cs_s;
   assign cmd_write  = live && !cs_s && ras_s && !cas_s && !we_s;
   assign cmd_act    = live && !cs_s && !ras_s && cas_s && we_s;
   assign cmd_pre    = live && !cs_s && !ras_s && cas_s && !we_s;
   assign cmd_ref    = rise && !self_refresh && !cs_s && !ras_s && !cas_s && we_s;
   assign ap_sel     = addr_s[AUTO_CLOSE_BIT];

   for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
      logic hit;
      assign hit = ba_s == BANK_W'(b);
      bank_tracker #(.RAS_MIN(RAS_MIN), .RP(RP)) u_bank (
         .clk         (clk),
         .resetn      (resetn),
         .tick        (rise),
         .activate    (cmd_act && hit),
         .precharge   (cmd_pre && (hit || ap_sel)),
         .auto_close  ((cmd_read || cmd_write) && hit && ap_sel),
         .close_delay (bl2),
         .row_open    (bank_open[b]),
         .precharging (bank_pre[b])
      );
   end

   // Refresh row counter and self refresh
   logic [SREF_W-1:0] sref_cnt_q;
   logic [WAIT_W-1:0] wait_cnt_q;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ref_row_q  <= '0;
         sref_cnt_q <= '0;
      end else if (self_refresh) begin
         // Own timer keeps rows refreshed with the link clock stopped
         if (sref_cnt_q == SREF_W'(SREF_INT - 1)) begin
            sref_cnt_q <= '0;
            ref_row_q  <= ref_row_q + 1'b1;
         end else begin
            sref_cnt_q <= sref_cnt_q + 1'b1;
         end
      end else if (cmd_ref && cke_s && cke_prev_q) begin
         ref_row_q  <= ref_row_q + 1'b1;
         sref_cnt_q <= '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         self_refresh  <= 1'b0;
         dll_en        <= 1'b1;
         dll_reset     <= 1'b0;
         other_term_en <= 1'b1;
         cke_term_en   <= 1'b1;
         read_ready    <= 1'b1;
         wait_cnt_q    <= '0;
      end else begin
         dll_reset <= 1'b0;
         if (!self_refresh && cmd_ref && !cke_s && cke_prev_q) begin
            self_refresh  <= 1'b1;
            dll_en        <= 1'b0;
            other_term_en <= 1'b0;
            read_ready    <= 1'b0;
         end else if (self_refresh && cke_s) begin
            // Exit watches the clock-enable level only, so a stopped link clock cannot trap it.
            self_refresh  <= 1'b0;
            dll_en        <= 1'b1;
            dll_reset     <= 1'b1;
            other_term_en <= 1'b1;
            wait_cnt_q    <= WAIT_W'(READ_WAIT);
         end else if (!read_ready && !self_refresh && rise) begin
            if (wait_cnt_q <= WAIT_W'(1)) begin
               read_ready <= 1'b1;
            end
            wait_cnt_q <= wait_cnt_q - 1'b1;
         end
      end
   end

   // DQ termination window, one bit per link clock ahead
   logic [TERM_W-1:0] term_off_q;
   logic [TERM_W-1:0] term_next;
   assign term_next = (term_off_q >> 1) | ((snoop_read && dual_q) ? win_mask(cl_q, bl2) : '0);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         term_off_q <= '0;
         dq_term_en <= 1'b1;
      end else begin
         if (rise) begin
            term_off_q <= term_next;
            // Termination drops in the very cycle that self refresh is entered
            dq_term_en <= !self_refresh && !(cmd_ref && !cke_s && cke_prev_q) && !term_next[0];
         end else if (self_refresh) begin
            dq_term_en <= 1'b0;
         end
      end
   end

   // Read latency pipe, one stage per link clock
   logic              pipe_v_q   [MAX_CL];
   logic [COL_W-1:0]  pipe_col_q [MAX_CL];
   logic [BANK_W-1:0] pipe_ba_q  [MAX_CL];
   logic [3:0]        load_idx;
   logic              load_now;
   assign load_idx = cl_q - 4'h2;
   assign load_now = rise && pipe_v_q[load_idx];

   always_ff @(posedge clk) begin
      if (!resetn) begin
         for (int i = 0; i < MAX_CL; i++) begin
            pipe_v_q[i]   <= 1'b0;
            pipe_col_q[i] <= '0;
            pipe_ba_q[i]  <= '0;
         end
      end else if (rise) begin
         pipe_v_q[0]   <= cmd_read;
         pipe_col_q[0] <= {addr_s[9], addr_s[7:0]};
         pipe_ba_q[0]  <= ba_s;
         for (int i = 1; i < MAX_CL; i++) begin
            pipe_v_q[i]   <= pipe_v_q[i-1];
            pipe_col_q[i] <= pipe_col_q[i-1];
            pipe_ba_q[i]  <= pipe_ba_q[i-1];
         end
      end
   end

   // Output engine in half link cycles: 0-1 preamble, 2..BL+1 data, BL+2 postamble.
   logic              busy_q, pend_q;
   logic [3:0]        half_q;
   logic [COL_W-1:0]  col_q, pend_col_q;
   logic [BANK_W-1:0] bank_q, pend_ba_q;
   logic [3:0]        last_data, post_half;
   assign last_data = bl_halves + 4'h1;
   assign post_half = bl_halves + 4'h2;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         busy_q                <= 1'b0;
         pend_q                <= 1'b0;
         half_q                <= 4'h0;
         col_q                 <= '0;
         bank_q                <= '0;
         pend_col_q            <= '0;
         pend_ba_q             <= '0;
         dq_out                <= '0;
         dq_oe_n               <= 1'b1;
         read_data_strobe      <= 1'b0;
         read_data_strobe_oe_n <= 1'b1;
      end else if (edge_t) begin
         if (load_now && (!busy_q || half_q == post_half)) begin
            busy_q                <= 1'b1;
            half_q                <= 4'h1;
            col_q                 <= pipe_col_q[load_idx];
            bank_q                <= pipe_ba_q[load_idx];
            read_data_strobe      <= 1'b1;
            read_data_strobe_oe_n <= 1'b0;
            dq_oe_n               <= 1'b1;
         end else if (busy_q) begin
            if (load_now) begin
               // Back-to-back READ: its preamble overlaps our last cycle, so it waits here.
               pend_q     <= 1'b1;
               pend_col_q <= pipe_col_q[load_idx];
               pend_ba_q  <= pipe_ba_q[load_idx];
            end
            read_data_strobe <= !half_q[0];
            if (half_q >= 4'h2 && half_q <= last_data) begin
               dq_out  <= data_word(bank_q, col_q, half_q - 4'h2);
               dq_oe_n <= 1'b0;
            end else begin
               dq_oe_n <= 1'b1;
            end
            if (half_q == last_data && pend_q) begin
               half_q <= 4'h2;
               col_q  <= pend_col_q;
               bank_q <= pend_ba_q;
               pend_q <= 1'b0;
            end else if (half_q == post_half) begin
               busy_q <= 1'b0;
            end else begin
               half_q <= half_q + 4'h1;
            end
         end else begin
            dq_oe_n               <= 1'b1;
            read_data_strobe_oe_n <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_model
   import dram_cmd_pkg::*;
(
   output logic              ck,    // Link clock, free running
   output logic              cke,   // Clock enable
   output logic              cs_n,  // Chip select
   output logic              ras_n, // Row strobe
   output logic              cas_n, // Column strobe
   output logic              we_n,  // Write enable
   output logic [BANK_W-1:0] ba,    // Bank address
   output logic [ROW_W-1:0]  addr   // Address
);
   initial begin
      ck = 1'b0;
      cke = 1'b1;
      {cs_n, ras_n, cas_n, we_n} = 4'h7;
      ba = '0;
      addr = '0;
   end
   // Clock never stops, so it is stable before clock-enable rises
   always #62.5 ck = ~ck;
   // Pins change on the falling edge; a NOP follows every command; DQ is never driven
   task automatic issue(input logic [3:0] c, input logic [BANK_W-1:0] b, input logic [ROW_W-1:0] a,
                        input logic k);
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n, ba, addr, cke} <= {c, b, a, k};
      @(negedge ck);
      {cs_n, ras_n, cas_n, we_n, ba, addr} <= {4'h7, ~b, ~a};
   endtask
endmodule
`default_nettype wire

// File: bench/dram_read_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dram_read_checker (
   input wire logic clk,                   // System clock
   input wire logic resetn,                // Reset, active low
   input wire logic dq_oe_n,               // DQ drive, low drives
   input wire logic read_data_strobe,      // Strobe level
   input wire logic read_data_strobe_oe_n, // Strobe drive, low drives
   input wire logic dq_term_en,            // DQ termination
   input wire logic other_term_en,         // Other pins termination
   input wire logic cke_term_en,           // Clock-enable termination
   input wire logic dll_en,                // DLL on
   input wire logic dll_reset,             // DLL reset pulse
   input wire logic self_refresh,          // Self refresh
   input wire logic read_ready             // Read wait done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_sr_exit;
      $fell(self_refresh);
   endsequence
   sequence s_burst_start;
      $fell(dq_oe_n);
   endsequence
   AST_CKE_TERM: assert property (cke_term_en) else $error("cke termination off");
   AST_OTHER_TERM: assert property (other_term_en == !self_refresh) else $error("other termination");
   AST_SR_OFF: assert property (self_refresh |-> !dll_en && !dq_term_en) else $error("sref dll/term");
   AST_DLL_RESET: assert property (s_sr_exit |-> ##[0:2] dll_reset) else $error("no dll reset");
   AST_DLL_PULSE: assert property (dll_reset |=> !dll_reset) else $error("dll reset too long");
   AST_SR_QUIET: assert property (self_refresh |-> dq_oe_n && !read_ready) else $error("sref active");
   AST_PREAMBLE: assert property (s_burst_start |-> !$past(read_data_strobe_oe_n, 8)) else $error("preamble");
   AST_STROBE_HI: assert property ($fell(read_data_strobe_oe_n) |-> read_data_strobe) else $error("pre high");
   AST_POSTAMBLE: assert property ($rose(dq_oe_n) |-> read_data_strobe && !read_data_strobe_oe_n)
      else $error("postamble");
   AST_DATA_STROBE: assert property (read_data_strobe_oe_n |-> dq_oe_n) else $error("data no strobe");
endmodule
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
   $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module testbench
   import dram_cmd_pkg::*;
();
   localparam logic [3:0] C_RD  = 4'h5;
   localparam logic [3:0] C_ACT = 4'h3;
   localparam logic [3:0] C_REF = 4'h1;
   logic              clk = 1'b0;
   logic              resetn = 1'b0;
   logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]        paddr = 8'h00;
   logic [31:0]       pwdata = 32'h0, prdata, rd, dq_out;
   logic [31:0]       first_q = 32'h0;
   logic              oe_d = 1'b1;
   logic              pready, pslverr, err, ck, cke, cs_n, ras_n, cas_n, we_n, dq_oe_n, rds, rds_oe_n, dq_term_en;
   logic [BANK_W-1:0] ba;
   logic [ROW_W-1:0]  addr;
   logic [11:0]       r0;
   int                failures = 0;
   int                cmp_count = 0;
   always #5 clk = ~clk;
   dram_read_ctrl #(.READ_WAIT(20), .SREF_INT(20)) i_dut (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .read_data_strobe(rds), .read_data_strobe_oe_n(rds_oe_n),
      .dq_term_en(dq_term_en), .other_term_en(), .cke_term_en(), .dll_en(), .dll_reset(), .self_refresh(),
      .read_ready());
   ctrl_model i_ctl (.ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba),
      .addr(addr));
   // First beat is taken where the drive starts, mid-cycle when it has settled
   always @(negedge clk) begin
      if (oe_d && dq_oe_n === 1'b0) first_q = dq_out;
      oe_d = dq_oe_n;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic t_regs();
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("status", 32'h0000000E, rd)
      apb(1'b0, CONFIG_OFS, 32'h0);
      `CHK("config", 32'h00000006, rd)
      apb(1'b1, 8'h10, 32'hFFFFFFFF);
      `CHK("unmapped", 33'h100000000, {err, rd})
   endtask
   // Snooped read with chip select high, then BL4 and BL8 reads, all dual load, CAS latency 3
   task automatic t_read();
      int off, drv, bl2;
      i_ctl.issue(C_ACT, 3'h2, 12'h001, 1'b1);
      for (int i = 0; i < 3; i++) begin
         bl2 = (i == 2) ? 4 : 2;
         apb(1'b1, CONFIG_OFS, (i == 2) ? 32'h33 : 32'h23);
         first_q = 32'h0;
         i_ctl.issue((i == 0) ? 4'hD : C_RD, 3'h2, 12'h2A5, 1'b1);
         off = 0;
         drv = 0;
         repeat (24) begin
            @(posedge ck);
            off += (dq_term_en === 1'b0);
            drv += (dq_oe_n === 1'b0);
         end
         `CHK("term_off", bl2 + TERM_EXTRA_CK, off)
         `CHK("beats", (i == 0) ? 0 : bl2, drv)
         `CHK("word0", (i == 0) ? 32'h0 : 32'h00005A50, first_q)
      end
   endtask
   // Auto close right after ACTIVE must wait for row-active time; bank 2 stays open until precharge all
   task automatic t_close();
      i_ctl.issue(C_ACT, 3'h5, 12'h010, 1'b1);
      i_ctl.issue(C_RD, 3'h5, 12'h100, 1'b1);
      repeat (3) @(posedge ck);
      apb(1'b0, BANKS_OFS, 32'h0);
      `CHK("row_held", 2'b11, {rd[5], rd[2]})
      repeat (12) @(posedge ck);
      apb(1'b0, BANKS_OFS, 32'h0);
      `CHK("row_closed", 4'b0001, {rd[13], rd[10], rd[5], rd[2]})
      i_ctl.issue(4'h2, 3'h0, 12'h100, 1'b1);
      apb(1'b0, BANKS_OFS, 32'h0);
      `CHK("pre_all", 2'b10, {rd[10], rd[2]})
      repeat (4) @(posedge ck);
   endtask
   task automatic t_refresh();
      apb(1'b0, REFROW_OFS, 32'h0);
      r0 = rd[11:0];
      i_ctl.issue(C_REF, 3'h7, 12'hFFF, 1'b1);
      repeat (2) @(posedge ck);
      apb(1'b0, REFROW_OFS, 32'h0);
      `CHK("refrow", r0 + 12'h001, rd[11:0])
      i_ctl.issue(C_REF, 3'h0, 12'h000, 1'b0);
      i_ctl.issue(C_RD, 3'h2, 12'h2A5, 1'b0);
      repeat (2) @(posedge ck);
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("sr_status", 32'h00000001, rd)
      apb(1'b0, REFROW_OFS, 32'h0);
      r0 = rd[11:0];
      // Setup edges exactly 40 clocks apart give two internal refreshes whatever the phase
      repeat (37) @(posedge clk);
      apb(1'b0, REFROW_OFS, 32'h0);
      `CHK("sr_rows", r0 + 12'h002, rd[11:0])
      i_ctl.issue(4'h7, 3'h0, 12'h000, 1'b1);
      repeat (5) @(posedge ck);
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("exit_status", 32'h00000006, rd)
      repeat (20) @(posedge ck);
      apb(1'b0, STATUS_OFS, 32'h0);
      `CHK("ready_status", 32'h0000000E, rd)
   endtask
   initial begin
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs();
      t_read();
      t_close();
      t_refresh();
      report_and_stop();
   end
   initial begin
      #1000000;
      failures++;
      report_and_stop();
   end
endmodule
bind dram_read_ctrl dram_read_checker i_chk (.clk(clk), .resetn(resetn), .dq_oe_n(dq_oe_n),
   .read_data_strobe(read_data_strobe), .read_data_strobe_oe_n(read_data_strobe_oe_n), .dq_term_en(dq_term_en),
   .other_term_en(other_term_en), .cke_term_en(cke_term_en), .dll_en(dll_en), .dll_reset(dll_reset),
   .self_refresh(self_refresh), .read_ready(read_ready));
`default_nettype wire
